/* pan_pkg.sv */
package pan_pkg;
	localparam logic [4:0] REG_IDENT_UPPER = 5'h02;
	localparam logic [4:0] REG_IDENT_LOWER = 5'h03;
	localparam logic [4:0] REG_ADVERT = 5'h04;
	localparam logic [4:0] REG_PARTNER = 5'h05;
	localparam logic [4:0] REG_EXPANSION = 5'h06;
	localparam logic [4:0] REG_RSVD_FIRST = 5'h08;
	localparam logic [4:0] REG_RSVD_LAST = 5'h0f;
	localparam logic [4:0] REG_UNIT_STATUS = 5'h10;
	// Arbitrary identifier value
	localparam logic [15:0] IDENT_UPPER_VAL = 16'h1234;
	// Arbitrary identifier value
	localparam logic [15:0] IDENT_LOWER_VAL = 16'h5678;
	localparam int ADV_NEXT_PAGE = 15;
	localparam int ADV_REMOTE_FAULT = 13;
	localparam int ADV_TECH_LSB = 5;
	localparam logic [7:0] ADV_TECH_RST = 8'h2f;
	localparam logic [4:0] ADV_SELECTOR = 5'h01;
	localparam int LP_ACK = 14;
	localparam int EXP_PD_FAULT = 4;
	localparam int EXP_LP_NP_ABLE = 3;
	localparam int EXP_NP_ABLE = 2;
	localparam int EXP_PAGE_RX = 1;
	localparam int EXP_LP_AN_ABLE = 0;
	localparam int UST_DISCONNECT = 13;
	localparam int UST_FLOW_CTRL = 12;
	localparam int UST_IN_SYNC = 11;
	localparam int UST_PD_100 = 10;
	localparam int UST_PD_10 = 9;
	localparam int UST_POLARITY = 8;
	localparam int UST_SPEED = 1;
	localparam int UST_DUPLEX = 0;
	localparam logic NEXT_PAGE_ABLE = 1'b0;

	typedef struct packed {
		logic [4:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} pan_bus_s;

	typedef struct packed {
		logic inSync;
		logic pd100;
		logic pd10;
		logic polarity;
		logic speed100;
		logic fullDuplex;
	} pan_phy_s;

	typedef struct packed {
		logic pageValid;
		logic [15:0] page;
		logic pageNew;
		logic pdFault;
		logic partnerAnAble;
	} pan_an_s;

	typedef struct packed {
		logic remoteFault;
		logic [7:0] techAbility;
		logic disconnectEn;
		logic flowCtrlEn;
	} pan_ctl_s;
endpackage

/* pan_regs.sv */
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// - Register 2 fixed upper identifier, writes ignored
// - Register 3 fixed lower identifier, writes ignored
// - Advertisement bit 15 always reads zero
// - Advertisement bit 13 writable remote fault
// - Advertisement bits 12:5 writable, reset 2f
// - Advertisement selector reads 00001 always
// - Partner register mirrors received base page
// - Partner bit 14 set once page received
// - Expansion bit 4 latches fault, read clears
// - Expansion bit 1 latches page, read clears
// - Expansion bits 3, 0 report partner ability
// - Expansion bit 2 reports local next page
// - Registers 8 to 15 reserved, no function
// - Register 16 bit 13 disconnect enable
// - Register 16 bit 12 flow control enable
// - Register 16 bit 11 deserializer sync
// - Register 16 bits 10:9 power down, reset 1
// - Register 16 bit 8 receive polarity
// - Register 16 bits 1:0 speed and duplex
module pan_regs (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Register port
	input wire pan_pkg::pan_bus_s bus,
	output pan_pkg::pan_bus_s unusedBus,
	output logic [15:0] rdData,
	// Status from the PHY core
	input wire pan_pkg::pan_phy_s phy,
	input wire pan_pkg::pan_an_s an,
	// Control to the PHY core
	output pan_pkg::pan_ctl_s ctl
);
	import pan_pkg::*;

	logic [15:0] rdData_r;
	logic [15:0] rdData_nxt;
	logic remoteFault_r;
	logic [7:0] tech_r;
	logic disconnect_r;
	logic flow_r;
	logic [15:0] partner_r;
	logic ack_r;
	logic pdFault_r;
	logic pageRx_r;
	logic lpNpAble_r;
	logic lpAnAble_r;
	logic inSync_r;
	logic pd100_r;
	logic pd10_r;
	logic pol_r;
	logic speed_r;
	logic duplex_r;
	pan_ctl_s ctl_r;
	logic expRead;

	function automatic logic isWrite(pan_bus_s b, logic [4:0] a);
		return b.wr && (b.addr == a);
	endfunction

	function automatic logic isRead(pan_bus_s b, logic [4:0] a);
		return b.rd && (b.addr == a);
	endfunction

	assign expRead = isRead(bus, REG_EXPANSION);
	assign unusedBus = '0;

	// Advertisement writable fields
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			remoteFault_r <= 1'b0;
			tech_r <= ADV_TECH_RST;
		end else if (clkEn && isWrite(bus, REG_ADVERT)) begin
			remoteFault_r <= bus.wdata[ADV_REMOTE_FAULT];
			tech_r <= bus.wdata[ADV_TECH_LSB +: 8];
		end
	end

	// Unit control bits; bits 15:14 dropped on write
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			disconnect_r <= 1'b0;
			flow_r <= 1'b0;
		end else if (clkEn && isWrite(bus, REG_UNIT_STATUS)) begin
			disconnect_r <= bus.wdata[UST_DISCONNECT];
			flow_r <= bus.wdata[UST_FLOW_CTRL];
		end
	end

	// Partner base page capture
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			partner_r <= 16'h0000;
			ack_r <= 1'b0;
			lpNpAble_r <= 1'b0;
			lpAnAble_r <= 1'b0;
		end else if (clkEn) begin
			lpAnAble_r <= an.partnerAnAble;
			if (an.pageValid) begin
				partner_r <= an.page;
				ack_r <= 1'b1;
				lpNpAble_r <= an.page[ADV_NEXT_PAGE];
			end
		end
	end

	// Latched-high bits: a new event wins over the read clear
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pdFault_r <= 1'b0;
			pageRx_r <= 1'b0;
		end else if (clkEn) begin
			if (an.pdFault)
				pdFault_r <= 1'b1;
			else if (expRead)
				pdFault_r <= 1'b0;
			if (an.pageNew)
				pageRx_r <= 1'b1;
			else if (expRead)
				pageRx_r <= 1'b0;
		end
	end

	// Unit status sampling
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			inSync_r <= 1'b0;
			pd100_r <= 1'b1;
			pd10_r <= 1'b1;
			pol_r <= 1'b0;
			speed_r <= 1'b0;
			duplex_r <= 1'b0;
		end else if (clkEn) begin
			inSync_r <= phy.inSync;
			pd100_r <= phy.pd100;
			pd10_r <= phy.pd10;
			pol_r <= phy.polarity;
			speed_r <= phy.speed100;
			duplex_r <= phy.fullDuplex;
		end
	end

	// Read mux; unlisted and reserved registers read zero
	always_comb begin
		rdData_nxt = 16'h0000;
		unique case (bus.addr)
			REG_IDENT_UPPER: rdData_nxt = IDENT_UPPER_VAL;
			REG_IDENT_LOWER: rdData_nxt = IDENT_LOWER_VAL;
			REG_ADVERT: begin
				rdData_nxt[ADV_NEXT_PAGE] = 1'b0;
				rdData_nxt[ADV_REMOTE_FAULT] = remoteFault_r;
				rdData_nxt[ADV_TECH_LSB +: 8] = tech_r;
				rdData_nxt[4:0] = ADV_SELECTOR;
			end
			REG_PARTNER: begin
				rdData_nxt = partner_r;
				rdData_nxt[LP_ACK] = ack_r;
			end
			REG_EXPANSION: begin
				rdData_nxt[EXP_PD_FAULT] = pdFault_r;
				rdData_nxt[EXP_LP_NP_ABLE] = lpNpAble_r;
				rdData_nxt[EXP_NP_ABLE] = NEXT_PAGE_ABLE;
				rdData_nxt[EXP_PAGE_RX] = pageRx_r;
				rdData_nxt[EXP_LP_AN_ABLE] = lpAnAble_r;
			end
			REG_UNIT_STATUS: begin
				rdData_nxt[UST_DISCONNECT] = disconnect_r;
				rdData_nxt[UST_FLOW_CTRL] = flow_r;
				rdData_nxt[UST_IN_SYNC] = inSync_r;
				rdData_nxt[UST_PD_100] = pd100_r;
				rdData_nxt[UST_PD_10] = pd10_r;
				rdData_nxt[UST_POLARITY] = pol_r;
				rdData_nxt[UST_SPEED] = speed_r;
				rdData_nxt[UST_DUPLEX] = duplex_r;
			end
			default: rdData_nxt = 16'h0000;
		endcase
	end

	// Read data stands after the strobe until the next enabled cycle, and holds while clkEn is low
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			rdData_r <= 16'h0000;
		else if (clkEn)
			rdData_r <= bus.rd ? rdData_nxt : 16'h0000;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			ctl_r <= '0;
		else if (clkEn) begin
			ctl_r.remoteFault <= remoteFault_r;
			ctl_r.techAbility <= tech_r;
			ctl_r.disconnectEn <= disconnect_r;
			ctl_r.flowCtrlEn <= flow_r;
		end
	end

	assign rdData = rdData_r;
	assign ctl = ctl_r;
endmodule

/* pan_regs_sva.sv */
`timescale 1ns/1ps
module pan_regs_sva (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Watched ports
	input wire pan_pkg::pan_bus_s bus,
	input wire logic [15:0] rdData,
	input wire pan_pkg::pan_an_s an
);
	import pan_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence rdAt(logic [4:0] a);
		clkEn && bus.rd && bus.addr == a;
	endsequence
	sequence still;
		clkEn && !bus.rd && !an.pdFault && !an.pageNew;
	endsequence
	a_ident_hi: assert property (rdAt(REG_IDENT_UPPER) |=>
		rdData == IDENT_UPPER_VAL) else $error("upper id");
	a_ident_lo: assert property (rdAt(REG_IDENT_LOWER) |=>
		rdData == IDENT_LOWER_VAL) else $error("lower id");
	a_adv_fixed: assert property (rdAt(REG_ADVERT) |=>
		rdData[15:14] == 2'h0 && rdData[4:0] == ADV_SELECTOR)
		else $error("advert");
	a_exp_fixed: assert property (rdAt(REG_EXPANSION) |=>
		rdData[15:5] == 11'h000 && rdData[EXP_NP_ABLE] == NEXT_PAGE_ABLE)
		else $error("expansion");
	a_rsvd_zero: assert property (clkEn && bus.rd &&
		bus.addr[4:3] == 2'h1 |=> rdData == 16'h0000) else $error("rsvd");
	a_latch_set: assert property (clkEn && an.pdFault &&
		an.pageNew ##1 rdAt(REG_EXPANSION) |=>
		rdData[EXP_PD_FAULT] && rdData[EXP_PAGE_RX]) else $error("set");
	a_read_clear: assert property (rdAt(REG_EXPANSION) ##0
		(!an.pdFault && !an.pageNew) ##1 still[*2] ##1 rdAt(REG_EXPANSION)
		|=> !rdData[EXP_PD_FAULT] && !rdData[EXP_PAGE_RX]) else $error("clr");
	a_page_copy: assert property (clkEn && an.pageValid ##1
		(!an.pageValid)[*6] ##1 rdAt(REG_PARTNER) |=>
		rdData == ($past(an.page, 8) | 16'h4000)) else $error("page");
endmodule
bind pan_regs pan_regs_sva pan_regs_sva_i (.clk_sys, .sys_rst, .clkEn,
	.bus, .rdData, .an);

/* pan_mgr.sv */
`timescale 1ns/1ps
module pan_mgr (
	// Clock
	input wire logic clk_sys,
	// Register port
	output pan_pkg::pan_bus_s bus,
	input wire logic [15:0] rdData
);
	import pan_pkg::*;
	initial bus = '0;
	task automatic w(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		bus <= '{a, a == REG_UNIT_STATUS ? d & 16'h3fff : d, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask
	task automatic r(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		bus <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		@(posedge clk_sys);
		d = rdData;
	endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	num_errors++; $display("unexpected %0t: %h", $time, g); end end
module testbench;
	import pan_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic clkEn = 1'b1;
	pan_bus_s bus;
	pan_phy_s phy = '0;
	pan_an_s an = '0;
	pan_ctl_s ctl;
	logic [15:0] rdData;
	int num_errors = 0;
	int samples_checked = 0;
	always #20 clk_sys = ~clk_sys;
	pan_regs pan_regs_i (.clk_sys, .sys_rst, .clkEn, .bus,
		.unusedBus(), .rdData, .phy, .an, .ctl);
	pan_mgr pan_mgr_i (.clk_sys, .bus, .rdData);
	task automatic rx(input logic [4:0] a, input logic [15:0] e);
		logic [15:0] d;
		pan_mgr_i.r(a, d);
		`CHK(d, e)
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rx(REG_ADVERT, 16'h05e1);
		rx(REG_EXPANSION, 16'h0000);
		$display("reset done");
		phy <= 6'h26;
		pan_mgr_i.w(REG_ADVERT, 16'hffff);
		pan_mgr_i.w(REG_UNIT_STATUS, 16'hffff);
		rx(REG_ADVERT, 16'h3fe1);
		rx(REG_UNIT_STATUS, 16'h3902);
		`CHK(ctl, 11'h7ff)
		for (int a = 2; a < 16; a++) begin
			if (a != 4) begin
				pan_mgr_i.w(5'(a), 16'hffff);
				rx(5'(a), a == 2 ? IDENT_UPPER_VAL :
					a == 3 ? IDENT_LOWER_VAL : 16'h0000);
			end
		end
		$display("write done");
		@(posedge clk_sys);
		an <= '{1'b1, 16'ha5a1, 1'b1, 1'b1, 1'b1};
		fork
			rx(REG_EXPANSION, 16'h001b);
			@(posedge clk_sys) an <= '{1'b0, 16'h0000, 1'b0, 1'b0, 1'b1};
		join
		rx(REG_EXPANSION, 16'h0009);
		rx(REG_PARTNER, 16'he5a1);
		$display("event done");
		@(posedge clk_sys);
		clkEn <= 1'b0;
		pan_mgr_i.w(REG_ADVERT, 16'h0000);
		@(posedge clk_sys);
		clkEn <= 1'b1;
		rx(REG_ADVERT, 16'h3fe1);
		$display("enable done");
		phy <= 6'h19;
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rx(REG_ADVERT, 16'h05e1);
		rx(REG_UNIT_STATUS, 16'h0601);
		rx(REG_PARTNER, 16'h0000);
		rx(REG_EXPANSION, 16'h0001);
		$display("rerun done");
		give_verdict();
	end
endmodule
